// ===== rtl/bap_regs.svh
// Register indices, field positions, reset values and timing counts for the blit
// address parameter bank.
// Assumes APB with 32-bit data: register index N sits at byte address 4*N.
`ifndef BAP_REGS_SVH
`define BAP_REGS_SVH

// Register indices (byte address is four times the index).
`define BAP_IDX_LIN_SEL    10'h100
`define BAP_IDX_DEPTH      10'h101
`define BAP_IDX_OP         10'h103
`define BAP_IDX_SRC_LO     10'h104
`define BAP_IDX_SRC_MID    10'h105
`define BAP_IDX_SRC_HI     10'h106
`define BAP_IDX_DST_LO     10'h108
`define BAP_IDX_DST_MID    10'h109
`define BAP_IDX_DST_HI     10'h10A
`define BAP_IDX_OFS_LO     10'h10C
`define BAP_IDX_OFS_HI     10'h10D
`define BAP_IDX_WID_LO     10'h110
`define BAP_IDX_WID_HI     10'h111
`define BAP_IDX_WALK_CTRL  10'h120
`define BAP_IDX_WALK_STAT  10'h121
`define BAP_IDX_CUR_SRC_LO 10'h122
`define BAP_IDX_CUR_SRC_MI 10'h123
`define BAP_IDX_CUR_SRC_HI 10'h124
`define BAP_IDX_CUR_DST_LO 10'h125
`define BAP_IDX_CUR_DST_MI 10'h126
`define BAP_IDX_CUR_DST_HI 10'h127

// Field positions.
`define BAP_LIN_SRC_BIT    0
`define BAP_LIN_DST_BIT    1
`define BAP_DEPTH16_BIT    0
`define BAP_WALK_START_BIT 0
`define BAP_WALK_STEP_BIT  1
`define BAP_WALK_STOP_BIT  2

// Reset values.
`define BAP_RST_BYTE       8'h00
`define BAP_RST_ADDR       21'h000000
`define BAP_RST_OFS        11'h000
`define BAP_RST_WID        10'h000
`define BAP_RST_OP         4'h0
`define BAP_RST_LIN        2'h0

// Timing: the slave answers every access in its first access cycle.
`define BAP_WAIT_STATES    0

`endif

// ===== rtl/bap_pkg.sv
// Types shared by the blit address parameter bank.
// Assumes nothing beyond a SystemVerilog compiler.
package bap_pkg;

    typedef enum logic [3:0] {
        BAP_OP_WRITE_RASTER_OPERATION = 4'h0,
        BAP_OP_READ                   = 4'h1,
        BAP_OP_MOVE_POS               = 4'h2,
        BAP_OP_MOVE_NEG               = 4'h3,
        BAP_OP_TWRITE                 = 4'h4,
        BAP_OP_TMOVE_POS              = 4'h5,
        BAP_OP_PAT_RASTER_OPERATION   = 4'h6,
        BAP_OP_PAT_TRANS              = 4'h7,
        BAP_OP_CEXP                   = 4'h8,
        BAP_OP_CEXP_TRANS             = 4'h9,
        BAP_OP_MOVE_CEXP              = 4'hA,
        BAP_OP_MOVE_CEXP_T            = 4'hB,
        BAP_OP_SOLID                  = 4'hC,
        BAP_OP_RSVD_D                 = 4'hD,
        BAP_OP_RSVD_E                 = 4'hE,
        BAP_OP_RSVD_F                 = 4'hF
    } bap_op_e;

    // Gray coded along idle -> walking.
    typedef enum logic [1:0] {
        BAP_ST_IDLE = 2'h0,
        BAP_ST_WALK = 2'h1
    } bap_state_e;

    typedef struct packed {
        logic [20:0] base;
        logic [2:0]  line;
        logic [3:0]  pixel;
    } bap_pat_s;

endpackage

// ===== rtl/bap_if.sv
// Register access carrier between the APB slave and the parameter bank.
// Assumes both ends run on the same clock.
interface bap_if;
    logic       wr;    // Write strobe, one cycle at the APB access edge.
    logic [9:0] idx;   // Register index.
    logic [7:0] wdata; // Write byte.
    logic [7:0] rdata; // Read byte for idx.
    logic       hit;   // Index is mapped.

    modport bus  (output wr, output idx, output wdata, input rdata, input hit);
    modport bank (input wr, input idx, input wdata, output rdata, output hit);
endinterface

// ===== rtl/bap_apb_slave.sv
// APB slave front end: decodes a word-aligned byte address into a register index.
// Assumes a conforming APB master on clk_sys; answers with no wait states.
module bap_apb_slave
    import bap_pkg::*;
(
    input  wire logic        clk_sys, // System clock.
    input  wire logic        rst,     // Synchronous reset, active high.
    input  wire logic        psel,    // APB select.
    input  wire logic        penable, // APB enable.
    input  wire logic        pwrite,  // APB direction.
    input  wire logic [11:0] paddr,   // APB byte address.
    input  wire logic [31:0] pwdata,  // APB write data.
    output logic      [31:0] prdata,  // APB read data.
    output logic             pready,  // APB ready.
    output logic             pslverr, // APB error.
    bap_if.bus               rb       // Register access.
);
    `include "bap_regs.svh"

    logic        aligned;
    logic        valid;
    logic [31:0] next_prdata;

    // Misaligned addresses are refused so byte registers never alias.
    assign aligned = (paddr[1:0] == 2'h0);
    assign valid   = aligned & rb.hit;
    assign rb.idx  = paddr[11:2];
    assign rb.wdata = pwdata[7:0];
    assign rb.wr   = psel & penable & pwrite & valid;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~valid;

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_comb begin
        next_prdata = prdata;
        if (psel & ~penable) begin
            next_prdata = (~pwrite & valid) ? {24'h000000, rb.rdata} : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule

// ===== rtl/bap_pat_decomp.sv
// Splits a source start address into pattern base, line and pixel parts and
// forms the pattern address for a chosen pattern line.
// Assumes purely combinational use inside the parameter bank.
module bap_pat_decomp
    import bap_pkg::*;
(
    input  wire logic     [20:0] src_start, // Programmed source start address.
    input  wire logic            depth16,   // One for 16 bits per pixel.
    input  wire logic     [2:0]  line_sel,  // Pattern line to address.
    output bap_pkg::bap_pat_s    fields,    // Decomposed start address.
    output logic          [20:0] pat_addr   // Address of pixel on line_sel.
);
    logic [20:0] line_bytes;

    always_comb begin
        if (depth16) begin
            fields.base  = {src_start[20:7], 7'h00};
            fields.line  = src_start[6:4];
            fields.pixel = src_start[3:0];
            line_bytes   = {14'h0000, line_sel, 4'h0};
        end else begin
            fields.base  = {src_start[20:6], 6'h00};
            fields.line  = src_start[5:3];
            fields.pixel = {1'b0, src_start[2:0]};
            line_bytes   = {15'h0000, line_sel, 3'h0};
        end
        // Base, line and pixel offsets add up to the address.
        pat_addr = fields.base + line_bytes + {17'h00000, fields.pixel};
    end
endmodule

// ===== rtl/bap_top.sv
// Blit address parameter bank: source/destination start, line offset and width,
// with a line walker that turns them into per-line start addresses.
// Assumes APB master on clk_sys; no wait states; outputs feed the blit engine.
//
// The APB slave port was decided locally.
module bap_top
    import bap_pkg::*;
(
    input  wire logic          clk_sys,      // System clock, 100 MHz.
    input  wire logic          rst,          // Synchronous reset, active high.
    input  wire logic          psel,         // APB select.
    input  wire logic          penable,      // APB enable.
    input  wire logic          pwrite,       // APB direction.
    input  wire logic   [11:0] paddr,        // APB byte address.
    input  wire logic   [31:0] pwdata,       // APB write data.
    output logic        [31:0] prdata,       // APB read data.
    output logic               pready,       // APB ready.
    output logic               pslverr,      // APB error.
    output bap_pkg::bap_op_e   op_code,      // Selected operation.
    output logic               depth16,      // One for 16 bits per pixel.
    output logic        [10:0] line_ofs,     // Line offset in words.
    output logic        [9:0]  width_m1,     // Width in pixels less one.
    output logic        [20:0] cur_src_addr, // Source start of current line.
    output logic        [20:0] cur_dst_addr, // Destination start of current line.
    output logic               dst_is_br,    // Destination is bottom-right corner.
    output logic               walk_busy     // Line walker active.
);
    import bap_pkg::*;
    `include "bap_regs.svh"

    bap_if rb ();

    bap_apb_slave u_apb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rb      (rb.bus)
    );

    // Parameter storage.
    logic [1:0]  lin_sel;
    logic [20:0] src_start;
    logic [20:0] dst_start;
    logic [1:0]  next_lin_sel;
    logic        next_depth16;
    bap_op_e     next_op_code;
    logic [20:0] next_src_start;
    logic [20:0] next_dst_start;
    logic [10:0] next_line_ofs;
    logic [9:0]  next_width_m1;

    // Walker state.
    bap_state_e  state;
    bap_state_e  next_state;
    logic [2:0]  pat_line;
    logic [2:0]  next_pat_line;
    logic [20:0] next_cur_src;
    logic [20:0] next_cur_dst;

    bap_pat_s    pat_fields;
    logic [20:0] pat_addr_now;
    logic [20:0] pat_addr_next;
    logic [20:0] src_step;
    logic [20:0] dst_step;
    logic        wr_ctrl;
    logic        cmd_start;
    logic        cmd_step;
    logic        cmd_stop;
    logic        neg_move;

    // Operations whose source data is written by the host processor.
    function automatic logic host_src(input bap_op_e op);
        case (op)
            BAP_OP_WRITE_RASTER_OPERATION, BAP_OP_TWRITE,
            BAP_OP_CEXP, BAP_OP_CEXP_TRANS: host_src = 1'b1;
            default: host_src = 1'b0;
        endcase
    endfunction

    function automatic logic pattern_op(input bap_op_e op);
        pattern_op = (op == BAP_OP_PAT_RASTER_OPERATION) || (op == BAP_OP_PAT_TRANS);
    endfunction

    // Bytes from one line start to the next on one side.
    function automatic logic [20:0] line_step(
        input logic        linear,
        input logic [9:0]  wid,
        input logic [10:0] ofs,
        input logic        b16
    );
        logic [10:0] npix;
        npix = {1'b0, wid} + 11'h001;
        if (linear) begin
            line_step = b16 ? {9'h000, npix, 1'b0} : {10'h000, npix};
        end else begin
            line_step = {9'h000, ofs, 1'b0};
        end
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        case (idx)
            `BAP_IDX_LIN_SEL, `BAP_IDX_DEPTH, `BAP_IDX_OP,
            `BAP_IDX_SRC_LO, `BAP_IDX_SRC_MID, `BAP_IDX_SRC_HI,
            `BAP_IDX_DST_LO, `BAP_IDX_DST_MID, `BAP_IDX_DST_HI,
            `BAP_IDX_OFS_LO, `BAP_IDX_OFS_HI, `BAP_IDX_WID_LO, `BAP_IDX_WID_HI,
            `BAP_IDX_WALK_CTRL, `BAP_IDX_WALK_STAT,
            `BAP_IDX_CUR_SRC_LO, `BAP_IDX_CUR_SRC_MI, `BAP_IDX_CUR_SRC_HI,
            `BAP_IDX_CUR_DST_LO, `BAP_IDX_CUR_DST_MI, `BAP_IDX_CUR_DST_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    bap_pat_decomp u_pat_now (
        .src_start (src_start),
        .depth16   (depth16),
        .line_sel  (pat_line),
        .fields    (pat_fields),
        .pat_addr  (pat_addr_now)
    );

    bap_pat_decomp u_pat_next (
        .src_start (src_start),
        .depth16   (depth16),
        .line_sel  (pat_line + 3'h1),
        .fields    (),
        .pat_addr  (pat_addr_next)
    );

    assign rb.hit = mapped(rb.idx);

    // Register writes: each byte lands alone, unused high bits are dropped.
    always_comb begin
        next_lin_sel   = lin_sel;
        next_depth16   = depth16;
        next_op_code   = op_code;
        next_src_start = src_start;
        next_dst_start = dst_start;
        next_line_ofs  = line_ofs;
        next_width_m1  = width_m1;
        if (rb.wr) begin
            case (rb.idx)
                `BAP_IDX_LIN_SEL: next_lin_sel = rb.wdata[1:0];
                `BAP_IDX_DEPTH:   next_depth16 = rb.wdata[`BAP_DEPTH16_BIT];
                `BAP_IDX_OP:      next_op_code = bap_op_e'(rb.wdata[3:0]);
                `BAP_IDX_SRC_LO:  next_src_start[7:0]   = rb.wdata;
                `BAP_IDX_SRC_MID: next_src_start[15:8]  = rb.wdata;
                `BAP_IDX_SRC_HI:  next_src_start[20:16] = rb.wdata[4:0];
                `BAP_IDX_DST_LO:  next_dst_start[7:0]   = rb.wdata;
                `BAP_IDX_DST_MID: next_dst_start[15:8]  = rb.wdata;
                `BAP_IDX_DST_HI:  next_dst_start[20:16] = rb.wdata[4:0];
                `BAP_IDX_OFS_LO:  next_line_ofs[7:0]    = rb.wdata;
                `BAP_IDX_OFS_HI:  next_line_ofs[10:8]   = rb.wdata[2:0];
                `BAP_IDX_WID_LO:  next_width_m1[7:0]    = rb.wdata;
                `BAP_IDX_WID_HI:  next_width_m1[9:8]    = rb.wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lin_sel   <= `BAP_RST_LIN;
            depth16   <= 1'b0;
            op_code   <= bap_op_e'(`BAP_RST_OP);
            src_start <= `BAP_RST_ADDR;
            dst_start <= `BAP_RST_ADDR;
            line_ofs  <= `BAP_RST_OFS;
            width_m1  <= `BAP_RST_WID;
        end else begin
            lin_sel   <= next_lin_sel;
            depth16   <= next_depth16;
            op_code   <= next_op_code;
            src_start <= next_src_start;
            dst_start <= next_dst_start;
            line_ofs  <= next_line_ofs;
            width_m1  <= next_width_m1;
        end
    end

    // Read mux; unused high bits return zero.
    always_comb begin
        case (rb.idx)
            `BAP_IDX_LIN_SEL:    rb.rdata = {6'h00, lin_sel};
            `BAP_IDX_DEPTH:      rb.rdata = {7'h00, depth16};
            `BAP_IDX_OP:         rb.rdata = {4'h0, op_code};
            `BAP_IDX_SRC_LO:     rb.rdata = src_start[7:0];
            `BAP_IDX_SRC_MID:    rb.rdata = src_start[15:8];
            `BAP_IDX_SRC_HI:     rb.rdata = {3'h0, src_start[20:16]};
            `BAP_IDX_DST_LO:     rb.rdata = dst_start[7:0];
            `BAP_IDX_DST_MID:    rb.rdata = dst_start[15:8];
            `BAP_IDX_DST_HI:     rb.rdata = {3'h0, dst_start[20:16]};
            `BAP_IDX_OFS_LO:     rb.rdata = line_ofs[7:0];
            `BAP_IDX_OFS_HI:     rb.rdata = {5'h00, line_ofs[10:8]};
            `BAP_IDX_WID_LO:     rb.rdata = width_m1[7:0];
            `BAP_IDX_WID_HI:     rb.rdata = {6'h00, width_m1[9:8]};
            `BAP_IDX_WALK_STAT:  rb.rdata = {3'h0, pat_line, dst_is_br, walk_busy};
            `BAP_IDX_CUR_SRC_LO: rb.rdata = cur_src_addr[7:0];
            `BAP_IDX_CUR_SRC_MI: rb.rdata = cur_src_addr[15:8];
            `BAP_IDX_CUR_SRC_HI: rb.rdata = {3'h0, cur_src_addr[20:16]};
            `BAP_IDX_CUR_DST_LO: rb.rdata = cur_dst_addr[7:0];
            `BAP_IDX_CUR_DST_MI: rb.rdata = cur_dst_addr[15:8];
            `BAP_IDX_CUR_DST_HI: rb.rdata = {3'h0, cur_dst_addr[20:16]};
            default:             rb.rdata = 8'h00;
        endcase
    end

    // Walker commands; the control register itself stores nothing.
    assign wr_ctrl   = rb.wr && (rb.idx == `BAP_IDX_WALK_CTRL);
    assign cmd_start = wr_ctrl & rb.wdata[`BAP_WALK_START_BIT];
    assign cmd_step  = wr_ctrl & rb.wdata[`BAP_WALK_STEP_BIT];
    assign cmd_stop  = wr_ctrl & rb.wdata[`BAP_WALK_STOP_BIT];

    assign neg_move  = (op_code == BAP_OP_MOVE_NEG);
    assign dst_is_br = neg_move;
    assign walk_busy = (state == BAP_ST_WALK);

    assign src_step = line_step(lin_sel[`BAP_LIN_SRC_BIT], width_m1, line_ofs, depth16);
    assign dst_step = line_step(lin_sel[`BAP_LIN_DST_BIT], width_m1, line_ofs, depth16);

    // Start loads the corner addresses, except that host-source operations take only bit 0 of the source start; each step moves the destination and,
    // except for host-source operations, the source one line, backwards for the negative move. Stop wins over step in the same write.
    always_comb begin
        next_state    = state;
        next_pat_line = pat_line;
        next_cur_src  = cur_src_addr;
        next_cur_dst  = cur_dst_addr;
        case (state)
            BAP_ST_IDLE: begin
                if (cmd_start) begin
                    next_state    = BAP_ST_WALK;
                    next_pat_line = pat_fields.line;
                    next_cur_dst  = dst_start;
                    if (host_src(op_code)) begin
                        next_cur_src = {20'h00000, src_start[0]};
                    end else if (pattern_op(op_code)) begin
                        next_cur_src = src_start;
                    end else begin
                        next_cur_src = src_start;
                    end
                end
            end
            BAP_ST_WALK: begin
                if (cmd_stop) begin
                    next_state = BAP_ST_IDLE;
                end else if (cmd_step) begin
                    if (neg_move) begin
                        next_cur_dst = cur_dst_addr - dst_step;
                        next_cur_src = cur_src_addr - src_step;
                    end else begin
                        next_cur_dst = cur_dst_addr + dst_step;
                        if (pattern_op(op_code)) begin
                            // The pattern is eight lines tall and wraps.
                            next_pat_line = pat_line + 3'h1;
                            next_cur_src  = pat_addr_next;
                        end else if (!host_src(op_code)) begin
                            next_cur_src = cur_src_addr + src_step;
                        end
                    end
                end
            end
            default: begin
                next_state = BAP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state        <= BAP_ST_IDLE;
            pat_line     <= 3'h0;
            cur_src_addr <= `BAP_RST_ADDR;
            cur_dst_addr <= `BAP_RST_ADDR;
        end else begin
            state        <= next_state;
            pat_line     <= next_pat_line;
            cur_src_addr <= next_cur_src;
            cur_dst_addr <= next_cur_dst;
        end
    end

    // The current-line pattern address is unused; only its line field is used, at start.
    logic unused_pat;
    assign unused_pat = ^pat_addr_now;
endmodule

// ===== tb/bap_top_asserts.sv
// Concurrent checks on the blit parameter bank, seen from its top-level ports.
// Assumes a bind onto bap_top; one clock, synchronous active-high reset.
module bap_top_asserts
    import bap_pkg::*;
(
    input wire logic          clk_sys,  // Clock.
    input wire logic          rst,      // Reset.
    input wire logic          psel,     // APB select.
    input wire logic          penable,  // APB enable.
    input wire logic          pwrite,   // APB direction.
    input wire logic   [11:0] paddr,    // APB address.
    input wire logic   [31:0] pwdata,   // APB write data.
    input wire logic   [31:0] prdata,   // APB read data.
    input wire logic          pready,   // APB ready.
    input wire bap_pkg::bap_op_e op_code, // Operation.
    input wire logic          depth16,  // Depth select.
    input wire logic   [10:0] line_ofs, // Line offset.
    input wire logic   [9:0]  width_m1, // Width less one.
    input wire logic          dst_is_br // Corner flag.
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A completed write: setup cycle, then the access edge.
    sequence s_wr(logic [9:0] idx);
        psel && !penable ##1 psel && penable && pwrite && pready && paddr == {idx, 2'b00};
    endsequence

    a_corner_flag: assert property (dst_is_br == (op_code == BAP_OP_MOVE_NEG))
        else $error("corner flag disagrees with operation");
    a_op_update: assert property (s_wr(10'h103) |=> op_code == $past(pwdata[3:0]))
        else $error("operation register not written");
    a_depth_update: assert property (s_wr(10'h101) |=> depth16 == $past(pwdata[0]))
        else $error("depth select not written");
    a_ofs_lo_write: assert property (s_wr(10'h10C) |=>
        line_ofs[7:0] == $past(pwdata[7:0]) && $stable(line_ofs[10:8]))
        else $error("line offset low byte wrong");
    a_ofs_hi_write: assert property (s_wr(10'h10D) |=>
        line_ofs[10:8] == $past(pwdata[2:0]) && $stable(line_ofs[7:0]))
        else $error("line offset high bits wrong");
    a_width_lo: assert property (s_wr(10'h110) |=> width_m1[7:0] == $past(pwdata[7:0]))
        else $error("width low byte wrong");
    a_width_hi: assert property (s_wr(10'h111) |=> width_m1[9:8] == $past(pwdata[1:0]))
        else $error("width high bits wrong");
    a_width_hold: assert property (!(psel && penable && pwrite) |=> $stable(width_m1))
        else $error("width changed without a write");
    a_read_upper: assert property (psel && penable && !pwrite |->
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule

// ===== tb/test_blit_address_parameter_regs.sv
// Self-checking bench for the blit parameter bank, driven over APB.
// Assumes bap_top answers with no wait states; checker bound at file end.
module test_blit_address_parameter_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import bap_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rv;
    logic        pready, pslverr, depth16, dst_is_br, walk_busy, ev;
    bap_op_e     op_code;
    logic [10:0] line_ofs;
    logic [9:0]  width_m1;
    logic [20:0] cur_src_addr, cur_dst_addr;
    int          n_errors = 0, tests_run = 0, cycles = 0;
    logic [9:0]  ti [10] = '{10'h104, 10'h105, 10'h106, 10'h108, 10'h109, 10'h10A,
                             10'h10C, 10'h10D, 10'h110, 10'h111};
    logic [7:0]  tw [10] = '{8'hA5, 8'h5A, 8'hFF, 8'hC3, 8'h3C, 8'hFF, 8'h96, 8'hFF, 8'h69,
                             8'hFF};
    logic [7:0]  te [10] = '{8'hA5, 8'h5A, 8'h1F, 8'hC3, 8'h3C, 8'h1F, 8'h96, 8'h07, 8'h69,
                             8'h03};

    bap_top dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_code(op_code), .depth16(depth16), .line_ofs(line_ofs),
        .width_m1(width_m1), .cur_src_addr(cur_src_addr), .cur_dst_addr(cur_dst_addr),
        .dst_is_br(dst_is_br), .walk_busy(walk_busy));

    initial forever #5 clk_sys = ~clk_sys;

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle cycle always precedes the setup cycle.
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the slave's answer.
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rv, {24'h000000, exp});
    endtask

    // Walker outputs land a cycle after the write; sample them mid-cycle.
    task automatic ctl(input logic [7:0] c);
        apb(1'b1, 10'h120, c);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rdc(ti[i], 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) apb(1'b1, ti[i], tw[i]);
        for (int i = 0; i < 10; i++) rdc(ti[i], te[i]);
        check({21'h000000, line_ofs}, 32'h00000796);
        check({22'h000000, width_m1}, 32'h00000369);
        $display("test byte_fields done");
        apb(1'b1, 10'h103, 8'h00);
        ctl(8'h04);
        ctl(8'h01);
        check({11'h000, cur_src_addr}, 32'h00000001);
        check({11'h000, cur_dst_addr}, 32'h001F3CC3);
        check({31'h00000000, walk_busy}, 32'h00000001);
        rdc(10'h121, 8'h11);
        ctl(8'h02);
        check({11'h000, cur_src_addr}, 32'h00000001);
        ctl(8'h04);
        check({31'h00000000, walk_busy}, 32'h00000000);
        $display("test host_source done");
        apb(1'b1, 10'h10D, 8'h00);
        apb(1'b1, 10'h10C, 8'h05);
        apb(1'b1, 10'h103, 8'h03);
        ctl(8'h01);
        ctl(8'h02);
        check({11'h000, cur_dst_addr}, 32'h001F3CB9);
        check({31'h00000000, dst_is_br}, 32'h00000001);
        apb(1'b1, 10'h100, 8'h02);
        apb(1'b1, 10'h101, 8'h00);
        apb(1'b1, 10'h110, 8'h03);
        apb(1'b1, 10'h111, 8'h00);
        ctl(8'h02);
        check({11'h000, cur_dst_addr}, 32'h001F3CB5);
        ctl(8'h04);
        apb(1'b1, 10'h103, 8'h02);
        ctl(8'h01);
        ctl(8'h02);
        check({11'h000, cur_dst_addr}, 32'h001F3CC7);
        ctl(8'h04);
        $display("test move_direction done");
        apb(1'b1, 10'h106, 8'h12);
        apb(1'b1, 10'h105, 8'h34);
        apb(1'b1, 10'h104, 8'hFF);
        apb(1'b1, 10'h103, 8'h06);
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, 10'h101, d[7:0]);
            ctl(8'h01);
            ctl(8'h02);
            check({11'h000, cur_src_addr}, d ? 32'h0012348F : 32'h001234C7);
            ctl(8'h02);
            check({11'h000, cur_src_addr}, d ? 32'h0012349F : 32'h001234CF);
            ctl(8'h04);
        end
        $display("test pattern_fill done");
        for (int op = 0; op < 16; op++) begin
            apb(1'b1, 10'h103, op[7:0]);
            ctl(8'h00);
            check({31'h00000000, dst_is_br}, {31'h00000000, op == 3});
        end
        apb(1'b1, 10'h0FF, 8'hFF);
        check({31'h00000000, ev}, 32'h00000001);
        rdc(10'h0FF, 8'h00);
        $display("test op_codes_and_unmapped done");
        final_report();
    end
endmodule

bind bap_top bap_top_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .op_code(op_code), .depth16(depth16), .line_ofs(line_ofs),
    .width_m1(width_m1), .dst_is_br(dst_is_br));
